// ---- pkg/mscp_regs.vh ----
// Constants for the motor serial configuration port: command codes,
// register indices, status and field bit positions, timing counts.
// Included by the port module; holds definitions only.
`ifndef MSCP_REGS_VH
`define MSCP_REGS_VH

// Command codes, first byte of every frame, sent MSB first
`define MSCP_CMD_STATUS_READ  8'h49
`define MSCP_CMD_STATUS_WRITE 8'h4A
`define MSCP_CMD_REG_READ     8'h51
`define MSCP_CMD_REG_WRITE    8'h52
`define MSCP_CMD_MEM_LOAD     8'h59
`define MSCP_CMD_MEM_SAVE     8'h5A
`define MSCP_CMD_MEM_ABORT    8'h5C

// Normal register indices (serial address byte)
`define MSCP_REG_USER_ID      4'h0
`define MSCP_REG_START_STOP   4'h1
`define MSCP_REG_CHANGE_CLAMP 4'h2
`define MSCP_REG_STARTUP      4'h3
`define MSCP_REG_SLOPE1       4'h4
`define MSCP_REG_SLOPE2       4'h5
`define MSCP_REG_LOOP_GAIN    4'h6
`define MSCP_REG_MOTOR_SENSOR 4'h7
`define MSCP_REG_OUTPUT_DRIVE 4'h8
`define MSCP_REG_LOCK_DETECT  4'h9
`define MSCP_REG_COUNT        10
`define MSCP_REG_RESET        16'h0000

// Status register bits
`define MSCP_SR_BUSY          0
`define MSCP_SR_CMD_ENABLE    1
`define MSCP_SR_WIRE          2
`define MSCP_SR_MEM_GATE      3
`define MSCP_SR_CAL_ERR       4
`define MSCP_SR_RESET         3'h0

// Field positions inside the normal registers
`define MSCP_CHANGE_DUTY_MSB  15
`define MSCP_CHANGE_DUTY_LSB  8
`define MSCP_SLOPE_MSB        15
`define MSCP_SLOPE_LSB        2
`define MSCP_LOOP_STYLE_BIT   0
`define MSCP_STANDBY_BIT      15
`define MSCP_TACHO_SRC_BIT    15
`define MSCP_SPEED_TYPE_BIT   11
`define MSCP_BLOCK_COMM_BIT   8

// Speed command duty scale: 512 counts equal 100 percent
`define MSCP_DUTY_HALF        10'h100

// Timing counts in mclk cycles
`define MSCP_FRAME_GAP        8'h40
`define MSCP_LOAD_CYCLES      8'h0A
`define MSCP_SAVE_CYCLES      8'hC8

`endif

// ---- rtl/mscp_port.v ----
// Serial configuration port and normal register bank of a motor
// pre-driver. The host shares the speed, tacho and alert pins as a
// 2-wire or 3-wire serial link; the serial clock arrives on the speed
// pin and is sampled by mclk. Speed duty, tacho and alarm signals come
// from the motor core on mclk. Non-volatile memory is modelled in flops.
//
// Behaviour
// - Change point sits at 200*field/512 percent duty
// - Zero change point field disables second slope
// - Above change point the second slope applies
// - Direction by duty: forward at or above half
// - Commands are taken only while tacho is released
// - Command code enters serial mode, stops motor
// - After frame, stay serial only if enable set
// - Enable clear admits only status read/write
// - Register commands: address byte, then sixteen data bits
// - Load command copies memory into normal registers
// - Save command stores normal registers into memory
// - Abort command ends a memory save early
// - Status busy bit high while work is pending
// - Status wire bit picks 3-wire or 2-wire link
// - Status gate bit picks memory read or write
// - Register 5 bit 0 picks open or closed loop
// - Register 7 bit 15 requests standby
// - Register 8 bit 11 picks analog or PWM input
// - Register 8 bit 15 picks tacho pin source
// - Register 8 bit 8 picks block commutation
`timescale 1ns/1ns
`include "mscp_regs.vh"

module mscp_port (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        speed_cmd_pin,
  input  wire        tacho_pin_in,
  output reg         tacho_pin_out,
  output reg         tacho_pin_oe,
  output reg         alert_pin_out,
  input  wire [9:0]  speed_duty,
  input  wire        direction_by_duty,
  input  wire        tacho_sig,
  input  wire        dir_alarm_sig,
  input  wire        alarm_sig,
  input  wire        cal_error,
  output reg         serial_mode,
  output reg         motor_stop,
  output reg         motor_forward,
  output reg         use_second_slope,
  output reg  [13:0] active_slope,
  output reg  [8:0]  change_point_level,
  output wire        loop_style_select,
  output wire        standby_request,
  output wire        speed_input_type,
  output wire        block_commutation_select,
  output wire [159:0] config_words
);

  // Frame states
  localparam [2:0] ST_CMD    = 3'd0;  // Waiting for command bits
  localparam [2:0] ST_SR_IN  = 3'd1;  // Status byte from host
  localparam [2:0] ST_SR_OUT = 3'd2;  // Status byte to host
  localparam [2:0] ST_ADDR   = 3'd3;  // Address byte from host
  localparam [2:0] ST_DIN    = 3'd4;  // Data word from host
  localparam [2:0] ST_DOUT   = 3'd5;  // Data word to host

  // Memory operation kinds
  localparam [1:0] OP_NONE = 2'd0;
  localparam [1:0] OP_LOAD = 2'd1;
  localparam [1:0] OP_SAVE = 2'd2;

  reg        sck_meta;       // Serial clock, first stage
  reg        sck_sync;       // Serial clock, second stage
  reg        sck_prev;       // Previous synchronised level
  reg        sdi_meta;       // Serial data, first stage
  reg        sdi_sync;       // Serial data, second stage
  reg  [2:0] state;          // Frame state
  reg  [4:0] bit_cnt;        // Bits seen in current field
  reg  [15:0] shift_in;      // Incoming bits
  reg  [15:0] shift_out;     // Outgoing bits, MSB on the wire
  reg        driving;        // Device owns the data line
  reg        reg_is_read;    // Register command direction
  reg  [7:0] reg_addr;       // Captured address byte
  reg        frame_busy;     // Register command in flight
  reg  [7:0] idle_cnt;       // mclk cycles since last serial edge
  reg        cmd_enable;     // Status: all commands admitted
  reg        wire_two;       // Status: 2-wire link
  reg        mem_gate;       // Status: memory write allowed
  reg        wr_stb;         // One-cycle register write strobe
  reg  [3:0] wr_index;       // Register written by wr_stb
  reg  [15:0] wr_data;       // Data for wr_stb
  reg  [1:0] op_kind;        // Memory operation in progress
  reg  [7:0] op_cnt;         // Cycles left in memory operation
  wire       sck_rise;       // Serial clock rising edge
  wire [7:0] in_byte;        // Byte completed this edge
  wire [15:0] in_word;       // Word completed this edge
  wire       op_done;        // Memory operation finishes now
  wire       load_done;      // Load finishes now
  wire       save_done;      // Save finishes now
  wire [7:0] status_byte;    // Status as read by the host
  reg  [15:0] read_word;     // Register selected by address
  wire       out_bit;        // Bit currently presented

  assign sck_rise  = sck_sync & ~sck_prev;
  assign in_byte   = {shift_in[6:0], sdi_sync};
  assign in_word   = {shift_in[14:0], sdi_sync};
  assign op_done   = (op_kind != OP_NONE) && (op_cnt == 8'h00);
  assign load_done = op_done && (op_kind == OP_LOAD);
  assign save_done = op_done && (op_kind == OP_SAVE);
  assign out_bit   = shift_out[15];
  // Busy covers register frames and memory work
  assign status_byte = {3'h0, cal_error, mem_gate, wire_two, cmd_enable,
                        frame_busy | (op_kind != OP_NONE)};

  // Two-stage synchronisers for the pin inputs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      sck_meta <= speed_cmd_pin;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      sdi_meta <= tacho_pin_in;
      sdi_sync <= sdi_meta;
    end
  end

  // Register bank and memory image, one entry per generate step
  genvar g;
  generate
    for (g = 0; g < `MSCP_REG_COUNT; g = g + 1) begin : entry
      reg [15:0] word;   // Normal register
      reg [15:0] stored; // Non-volatile copy
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          word   <= `MSCP_REG_RESET;
          stored <= `MSCP_REG_RESET;
        end else begin
          if (load_done) begin
            word <= stored;
          end else if (wr_stb && (wr_index == g)) begin
            word <= wr_data;
          end
          if (save_done) begin
            stored <= word;
          end
        end
      end
      assign config_words[16*g +: 16] = word;
    end
  endgenerate

  // Read mux on the address byte completing now; past the bank reads zero
  always @* begin
    if (in_byte < `MSCP_REG_COUNT) begin
      read_word = config_words[{in_byte[3:0], 4'h0} +: 16];
    end else begin
      read_word = 16'h0000;
    end
  end

  // Configuration fields, taken straight from register flops
  assign loop_style_select = config_words[16*`MSCP_REG_SLOPE2 +
                             `MSCP_LOOP_STYLE_BIT];
  assign standby_request   = config_words[16*`MSCP_REG_MOTOR_SENSOR +
                             `MSCP_STANDBY_BIT];
  assign speed_input_type  = config_words[16*`MSCP_REG_OUTPUT_DRIVE +
                             `MSCP_SPEED_TYPE_BIT];
  assign block_commutation_select =
    config_words[16*`MSCP_REG_OUTPUT_DRIVE + `MSCP_BLOCK_COMM_BIT];

  // Serial frame engine
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_CMD;
      bit_cnt     <= 5'd0;
      shift_in    <= 16'h0000;
      shift_out   <= 16'h0000;
      driving     <= 1'b0;
      reg_is_read <= 1'b0;
      reg_addr    <= 8'h00;
      frame_busy  <= 1'b0;
      idle_cnt    <= 8'h00;
      serial_mode <= 1'b0;
      cmd_enable  <= 1'b0;
      wire_two    <= 1'b0;
      mem_gate    <= 1'b0;
      wr_stb      <= 1'b0;
      wr_index    <= 4'h0;
      wr_data     <= 16'h0000;
      op_kind     <= OP_NONE;
      op_cnt      <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      // Memory operation countdown
      if (op_done) begin
        op_kind <= OP_NONE;
      end else if (op_kind != OP_NONE) begin
        op_cnt <= op_cnt - 8'h01;
      end
      if (sck_rise) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt != `MSCP_FRAME_GAP) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
      // A stalled frame is dropped so the next command starts clean
      if (!sck_rise && (idle_cnt == `MSCP_FRAME_GAP - 8'h01) &&
          ((state != ST_CMD) || (bit_cnt != 5'd0))) begin
        state       <= ST_CMD;
        bit_cnt     <= 5'd0;
        driving     <= 1'b0;
        frame_busy  <= 1'b0;
        serial_mode <= cmd_enable;
      end else if (sck_rise) begin
        case (state)
          ST_CMD: begin
            // Bits only count while the tacho pin is released
            if (!tacho_pin_oe) begin
              shift_in <= in_word;
              if (bit_cnt != 5'd7) begin
                bit_cnt <= bit_cnt + 5'd1;
              end else begin
                bit_cnt     <= 5'd0;
                serial_mode <= 1'b1;
                if (in_byte == `MSCP_CMD_STATUS_READ) begin
                  shift_out <= {status_byte, 8'h00};
                  driving   <= 1'b1;
                  state     <= ST_SR_OUT;
                end else if (in_byte == `MSCP_CMD_STATUS_WRITE) begin
                  state <= ST_SR_IN;
                end else if (!cmd_enable) begin
                  serial_mode <= 1'b0;
                end else if ((in_byte == `MSCP_CMD_REG_READ) ||
                             (in_byte == `MSCP_CMD_REG_WRITE)) begin
                  reg_is_read <= in_byte[0];
                  frame_busy  <= 1'b1;
                  state       <= ST_ADDR;
                end else if (in_byte == `MSCP_CMD_MEM_LOAD) begin
                  // Reads of memory only while the gate is clear
                  if (!mem_gate && (op_kind == OP_NONE)) begin
                    op_kind <= OP_LOAD;
                    op_cnt  <= `MSCP_LOAD_CYCLES;
                  end
                end else if (in_byte == `MSCP_CMD_MEM_SAVE) begin
                  if (mem_gate && (op_kind == OP_NONE)) begin
                    op_kind <= OP_SAVE;
                    op_cnt  <= `MSCP_SAVE_CYCLES;
                  end
                end else if (in_byte == `MSCP_CMD_MEM_ABORT) begin
                  if (op_kind == OP_SAVE) begin
                    op_kind <= OP_NONE;
                  end
                end
              end
            end
          end
          ST_SR_IN: begin
            shift_in <= in_word;
            if (bit_cnt != 5'd7) begin
              bit_cnt <= bit_cnt + 5'd1;
            end else begin
              bit_cnt     <= 5'd0;
              cmd_enable  <= in_byte[`MSCP_SR_CMD_ENABLE];
              wire_two    <= in_byte[`MSCP_SR_WIRE];
              mem_gate    <= in_byte[`MSCP_SR_MEM_GATE];
              serial_mode <= in_byte[`MSCP_SR_CMD_ENABLE];
              state       <= ST_CMD;
            end
          end
          ST_ADDR: begin
            shift_in <= in_word;
            if (bit_cnt != 5'd7) begin
              bit_cnt <= bit_cnt + 5'd1;
            end else begin
              bit_cnt  <= 5'd0;
              reg_addr <= in_byte;
              if (reg_is_read) begin
                // Mux indexes by the byte completing on this edge
                shift_out <= read_word;
                driving <= 1'b1;
                state   <= ST_DOUT;
              end else begin
                state <= ST_DIN;
              end
            end
          end
          ST_DIN: begin
            shift_in <= in_word;
            if (bit_cnt != 5'd15) begin
              bit_cnt <= bit_cnt + 5'd1;
            end else begin
              bit_cnt     <= 5'd0;
              wr_stb      <= (reg_addr < `MSCP_REG_COUNT);
              wr_index    <= reg_addr[3:0];
              wr_data     <= in_word;
              frame_busy  <= 1'b0;
              serial_mode <= cmd_enable;
              state       <= ST_CMD;
            end
          end
          ST_SR_OUT, ST_DOUT: begin
            // Host samples on this rise; present the next bit
            shift_out <= {shift_out[14:0], 1'b0};
            if (bit_cnt != ((state == ST_DOUT) ? 5'd15 : 5'd7)) begin
              bit_cnt <= bit_cnt + 5'd1;
            end else begin
              bit_cnt     <= 5'd0;
              driving     <= 1'b0;
              frame_busy  <= 1'b0;
              serial_mode <= cmd_enable;
              state       <= ST_CMD;
            end
          end
          default: begin
            state   <= ST_CMD;
            bit_cnt <= 5'd0;
          end
        endcase
      end
    end
  end

  // Pin drivers; tacho is open-drain outside serial mode
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tacho_pin_out <= 1'b0;
      tacho_pin_oe  <= 1'b0;
      alert_pin_out <= 1'b0;
    end else begin
      if (serial_mode) begin
        // Released unless answering on the 2-wire link
        tacho_pin_out <= out_bit;
        tacho_pin_oe  <= driving & wire_two;
      end else begin
        tacho_pin_out <= 1'b0;
        if (config_words[16*`MSCP_REG_OUTPUT_DRIVE +
                         `MSCP_TACHO_SRC_BIT]) begin
          tacho_pin_oe <= ~dir_alarm_sig;
        end else begin
          tacho_pin_oe <= ~tacho_sig;
        end
      end
      // 3-wire answers leave on the alert pin
      if (serial_mode && !wire_two) begin
        alert_pin_out <= driving ? out_bit : 1'b1;
      end else begin
        alert_pin_out <= alarm_sig;
      end
    end
  end

  // Speed curve selection and motor control outputs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      motor_stop         <= 1'b0;
      motor_forward      <= 1'b1;
      use_second_slope   <= 1'b0;
      active_slope       <= 14'h0000;
      change_point_level <= 9'h000;
    end else begin
      motor_stop <= serial_mode | standby_request;
      // 200/512 percent per step is two counts of the 512 scale
      change_point_level <= {config_words[16*`MSCP_REG_CHANGE_CLAMP +
                             `MSCP_CHANGE_DUTY_LSB +: 8], 1'b0};
      use_second_slope <= (change_point_level != 9'h000) &&
                          (speed_duty > {1'b0, change_point_level});
      if (use_second_slope) begin
        active_slope <= config_words[16*`MSCP_REG_SLOPE2 +
                                     `MSCP_SLOPE_LSB +: 14];
      end else begin
        active_slope <= config_words[16*`MSCP_REG_SLOPE1 +
                                     `MSCP_SLOPE_LSB +: 14];
      end
      motor_forward <= ~direction_by_duty |
                       (speed_duty >= `MSCP_DUTY_HALF);
    end
  end

endmodule // mscp_port

// ---- verif/mscp_assertions.sv ----
// Checker for the serial configuration port, bound to its top module.
// Assumes the bench holds direction_by_duty low while in reset.
`timescale 1ns/1ns
module mscp_assertions (
  input wire         mclk,
  input wire         rst_n,
  input wire         tacho_pin_oe,
  input wire [9:0]   speed_duty,
  input wire         direction_by_duty,
  input wire         serial_mode,
  input wire         motor_stop,
  input wire         motor_forward,
  input wire         use_second_slope,
  input wire [13:0]  active_slope,
  input wire [8:0]   change_point_level,
  input wire         loop_style_select,
  input wire         standby_request,
  input wire         speed_input_type,
  input wire         block_commutation_select,
  input wire [159:0] config_words
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Stop flag lags its two causes by one cycle
  a_stop_cause: assert property (motor_stop ==
    ($past(serial_mode) || $past(standby_request)))
    else $error("motor stop does not follow its causes");
  a_dir_duty: assert property (motor_forward ==
    $past(!direction_by_duty || speed_duty >= 10'h100))
    else $error("direction disagrees with duty");
  // Guards skip the cycle where the level, the slope choice or a source field moves
  a_slope_pick: assert property ($stable(change_point_level) |->
    use_second_slope == ($past(change_point_level) != 9'h000 &&
    $past(speed_duty) > {1'b0, $past(change_point_level)}))
    else $error("second slope choice wrong");
  a_slope_value: assert property ($stable(use_second_slope) &&
    $stable(config_words[95:66]) |-> active_slope ==
    (use_second_slope ? config_words[95:82] : config_words[79:66]))
    else $error("active slope wrong");
  a_change_lvl: assert property ($stable(config_words[47:40]) |->
    change_point_level == {config_words[47:40], 1'b0})
    else $error("change point level wrong");
  a_loop_standby_request: assert property (loop_style_select ==
    config_words[80] && standby_request == config_words[127])
    else $error("loop style or standby bit wrong");
  a_input_comm: assert property (speed_input_type ==
    config_words[139] && block_commutation_select == config_words[136])
    else $error("speed input or commutation bit wrong");
  // A driven tacho pin keeps the port deaf
  a_busy_pin: assert property (!serial_mode && tacho_pin_oe
    |=> !serial_mode)
    else $error("command taken while tacho pin driven");
  a_cfg_serial: assert property (!$stable(config_words)
    |-> $past(serial_mode))
    else $error("registers changed outside serial mode");

  c_enter: cover property ($rose(serial_mode));
  c_second: cover property (use_second_slope);
  c_answer: cover property (serial_mode && tacho_pin_oe);
endmodule // mscp_assertions

bind mscp_port mscp_assertions i_mscp_assertions (
  .mclk(mclk), .rst_n(rst_n), .tacho_pin_oe(tacho_pin_oe),
  .speed_duty(speed_duty), .direction_by_duty(direction_by_duty),
  .serial_mode(serial_mode), .motor_stop(motor_stop),
  .motor_forward(motor_forward), .use_second_slope(use_second_slope),
  .active_slope(active_slope), .change_point_level(change_point_level),
  .loop_style_select(loop_style_select),
  .standby_request(standby_request), .speed_input_type(speed_input_type),
  .block_commutation_select(block_commutation_select),
  .config_words(config_words));

// ---- verif/mscp_host.sv ----
// Host model for the shared serial pins: clock on the speed pin.
// Assumes the bench resolves the tacho wire with a pull-up.
`timescale 1ns/1ns
module mscp_host (
  input  wire wire2,
  input  wire tacho_wire,
  input  wire alert,
  output reg  sck,
  output reg  hd,
  output reg  hd_en
);
  // Clock idles low, data line released between frames
  initial begin
    sck = 1'b0;
    hd = 1'b0;
    hd_en = 1'b0;
  end
  // One frame MSB first; host drives the first nout bits only
  task xfer(input int n, input int nout, input logic [31:0] dout,
            output logic [31:0] din);
    int i;
    begin
      din = 32'h0;
      for (i = n - 1; i >= 0; i--) begin
        hd_en = (n - 1 - i) < nout;
        hd = dout[i];
        #160;
        din[i] = wire2 ? tacho_wire : alert;
        sck = 1'b1;
        #160;
        sck = 1'b0;
      end
      hd_en = 1'b0;
    end
  endtask
endmodule // mscp_host

// ---- verif/tb_top.sv ----
// Bench: frames through the host model, then core-side outputs.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ns
`include "mscp_regs.vh"
module tb_top;
  reg          mclk, rst_n, direction_by_duty, dir_alarm_sig, wire2;
  reg          tacho_sig, cal_error;
  reg  [9:0]   speed_duty;
  wire         sck, hd, hd_en, tacho_pin_out, tacho_pin_oe, alert_pin_out;
  wire         serial_mode, motor_stop, motor_forward, use_second_slope;
  wire         loop_style_select, standby_request, speed_input_type;
  wire         block_commutation_select;
  wire [13:0]  active_slope;
  wire [8:0]   change_point_level;
  wire [159:0] config_words;
  int          n_fail, checked, a;
  logic [7:0]  s;
  logic [15:0] d;
  // Open-drain tacho wire with pull-up
  wire tacho_wire = tacho_pin_oe ? tacho_pin_out : (hd_en ? hd : 1'b1);

  mscp_port i_mscp_port (.mclk(mclk), .rst_n(rst_n),
    .speed_cmd_pin(sck), .tacho_pin_in(tacho_wire),
    .tacho_pin_out(tacho_pin_out), .tacho_pin_oe(tacho_pin_oe),
    .alert_pin_out(alert_pin_out), .speed_duty(speed_duty),
    .direction_by_duty(direction_by_duty), .tacho_sig(tacho_sig),
    .dir_alarm_sig(dir_alarm_sig), .alarm_sig(1'b0), .cal_error(cal_error),
    .serial_mode(serial_mode), .motor_stop(motor_stop),
    .motor_forward(motor_forward), .use_second_slope(use_second_slope),
    .active_slope(active_slope), .change_point_level(change_point_level),
    .loop_style_select(loop_style_select),
    .standby_request(standby_request), .speed_input_type(speed_input_type),
    .block_commutation_select(block_commutation_select),
    .config_words(config_words));
  mscp_host i_mscp_host (.wire2(wire2), .tacho_wire(tacho_wire),
    .alert(alert_pin_out), .sck(sck), .hd(hd), .hd_en(hd_en));

  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Frame plus settle time for the sync pipeline
  task frame(input int n, input int no, input logic [31:0] v,
             output logic [31:0] r);
    i_mscp_host.xfer(n, no, v, r);
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task cmd(input logic [7:0] c);
    logic [31:0] r;
    frame(8, 8, {24'h0, c}, r);
  endtask
  task sr_rd(output logic [7:0] v);
    logic [31:0] r;
    frame(16, 8, {16'h0, `MSCP_CMD_STATUS_READ, 8'h00}, r);
    v = r[7:0];
  endtask
  task sr_wr(input logic [7:0] v);
    logic [31:0] r;
    frame(16, 16, {16'h0, `MSCP_CMD_STATUS_WRITE, v}, r);
  endtask
  task rg_wr(input int ad, input logic [15:0] v);
    logic [31:0] r;
    frame(32, 32, {`MSCP_CMD_REG_WRITE, 8'(ad), v}, r);
  endtask
  task rg_rd(input int ad, output logic [15:0] v);
    logic [31:0] r;
    frame(32, 16, {`MSCP_CMD_REG_READ, 8'(ad), 16'h0}, r);
    v = r[15:0];
  endtask
  // Poll busy, bounded
  task idle;
    for (int k = 0; k < 20; k++) begin
      sr_rd(s);
      if (s[0] === 1'b0) break;
    end
    chk(s[0], 1'b0);
  endtask
  task core(input logic [9:0] v, input logic dr);
    @(posedge mclk);
    #1 speed_duty = v;
    direction_by_duty = dr;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  function automatic logic [15:0] dat(input int n);
    dat = 16'h8901 | 16'(n << 4);
  endfunction

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole run is about 10k cycles
  initial begin
    #2000000;
    n_fail++;
    give_verdict;
  end
  initial begin
    rst_n = 1'b0;
    speed_duty = 10'h000;
    direction_by_duty = 1'b0;
    dir_alarm_sig = 1'b1;
    tacho_sig = 1'b1;
    cal_error = 1'b0;
    wire2 = 1'b0;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(|config_words, 1'b0);
    tacho_sig = 1'b0;
    core(10'h000, 1'b0);
    chk(tacho_pin_oe, 1'b1);
    tacho_sig = 1'b1;
    core(10'h000, 1'b0);
    chk(tacho_pin_oe, 1'b0);
    sr_rd(s);
    chk(s, 8'h00);
    rg_wr(1, 16'hFFFF);
    chk(|config_words, 1'b0);
    chk(serial_mode, 1'b0);
    sr_wr(8'h02);
    chk({serial_mode, motor_stop}, 2'b11);
    for (a = 0; a <= 10; a++) rg_wr(a, dat(a));
    for (a = 0; a <= 10; a++) begin
      rg_rd(a, d);
      chk(d, a < 10 ? dat(a) : 16'h0);
      if (a < 10) chk(config_words[16 * a +: 16], dat(a));
    end
    sr_wr(8'h06);
    wire2 = 1'b1;
    rg_rd(8, d);
    chk(d, dat(8));
    sr_rd(s);
    chk(s, 8'h06);
    sr_wr(8'h02);
    wire2 = 1'b0;
    chk({loop_style_select, standby_request, speed_input_type,
         block_commutation_select}, 4'hF);
    chk(change_point_level, 9'h112);
    core(10'h113, 1'b0);
    chk({use_second_slope, active_slope}, {1'b1, 14'(dat(5) >> 2)});
    core(10'h112, 1'b0);
    chk({use_second_slope, active_slope}, {1'b0, 14'(dat(4) >> 2)});
    rg_wr(2, 16'h0001);
    core(10'h3FF, 1'b1);
    chk({use_second_slope, motor_forward}, 2'b01);
    core(10'h0FF, 1'b1);
    chk(motor_forward, 1'b0);
    core(10'h100, 1'b1);
    chk(motor_forward, 1'b1);
    sr_wr(8'h0A);
    cmd(`MSCP_CMD_MEM_SAVE);
    sr_rd(s);
    chk(s, 8'h0B);
    idle;
    rg_wr(0, 16'h1234);
    cmd(`MSCP_CMD_MEM_LOAD);
    rg_rd(0, d);
    chk(d, 16'h1234);
    cmd(`MSCP_CMD_MEM_SAVE);
    cmd(`MSCP_CMD_MEM_ABORT);
    sr_rd(s);
    chk(s, 8'h0A);
    sr_wr(8'h02);
    cmd(`MSCP_CMD_MEM_SAVE);
    cmd(`MSCP_CMD_MEM_LOAD);
    idle;
    rg_rd(0, d);
    chk(d, dat(0));
    sr_wr(8'h00);
    chk({serial_mode, motor_stop}, 2'b01);
    core(10'h100, 1'b1);
    dir_alarm_sig = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(tacho_pin_oe, 1'b1);
    sr_wr(8'h02);
    chk(serial_mode, 1'b0);
    core(10'h100, 1'b1);
    dir_alarm_sig = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(tacho_pin_oe, 1'b0);
    cal_error = 1'b1;
    sr_rd(s);
    chk(s, 8'h10);
    give_verdict;
  end
endmodule // tb_top
